// ---- core/fhat_pkg.sv ----
// Constants shared by the host access timing port and its helpers
package fhat_pkg;
	// Data, wait and counter widths; FIFO depth
	localparam int DATA_W = 16;
	localparam int WAIT_W = 5;
	localparam int CNT_W = 6;
	localparam int FIFO_DEPTH = 16;

	// Synchroniser input bundle bit positions
	localparam int SY_AD_LSB = 0;
	localparam int SY_ACS = 16;
	localparam int SY_SCS = 17;
	localparam int SY_ADV = 18;
	localparam int SY_OE = 19;
	localparam int SY_WE = 20;
	localparam int SY_IFCLK = 21;
	localparam int SY_DMA = 22;
	localparam int SY_SRC = 23;
	localparam int SY_FRQ = 24;
	localparam int SY_W = 25;

	// Address layout of the latched multiplexed address
	localparam int ADDR_FIFO_BIT = 15;
	localparam int ADDR_WIDE_BIT = 14;
	localparam logic [15:0] WAIT_REG_ADDR = 16'h0010;

	// Reset values
	localparam logic [WAIT_W-1:0] WAIT_RST = 5'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	// Core clock cycles from a pin edge to the cycle that acts on it
	localparam int SYNC_LAT = 3;

	// Total ready delays in core clocks, pin edge to ready high
	localparam int RD16_DLY = 7;
	localparam int RD32A_DLY = 6;
	localparam int RD32B_DLY = 3;
	localparam int RDFIFO_DLY = 4;
	localparam int WR16_DLY = 4;
	localparam int WR32A_DLY = 3;
	localparam int WR32B_DLY = 5;
	localparam int WRFIFO_DLY = 4;

	// Counter loads derived from the totals
	localparam logic [CNT_W-1:0] RD16_LD = CNT_W'(RD16_DLY - SYNC_LAT);
	localparam logic [CNT_W-1:0] RD32A_LD = CNT_W'(RD32A_DLY - SYNC_LAT);
	localparam logic [CNT_W-1:0] RD32B_LD = CNT_W'(RD32B_DLY - SYNC_LAT);
	localparam logic [CNT_W-1:0] RDFIFO_LD = CNT_W'(RDFIFO_DLY - SYNC_LAT);
	localparam logic [CNT_W-1:0] WR16_LD = CNT_W'(WR16_DLY - SYNC_LAT);
	localparam logic [CNT_W-1:0] WR32A_LD = CNT_W'(WR32A_DLY - SYNC_LAT);
	localparam logic [CNT_W-1:0] WR32B_LD = CNT_W'(WR32B_DLY - SYNC_LAT);
	localparam logic [CNT_W-1:0] WRFIFO_LD = CNT_W'(WRFIFO_DLY - SYNC_LAT);

	// Burst wait count: 0 or 1 give a single interface clock
	localparam logic [WAIT_W-1:0] WAIT_MIN_EFF = 5'h01;
	localparam logic [CNT_W-1:0] BURST_ONE = 6'h01;

	// Fastest interface clock the host may run, in picoseconds
	localparam int IFCLK_MIN_PERIOD_PS = 14800;

	// Nominal reference clocks, in kHz
	localparam int REFCLK_HIGH_KHZ = 38400;
	localparam int REFCLK_LOW_KHZ = 19200;

	// Core clock rate and strap capture delay
	localparam int CORE_CLK_KHZ = 20000;
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	typedef enum logic [2:0] {
		FH_IDLE,
		FH_WAIT,
		FH_READY,
		FH_BWAIT,
		FH_BURST
	} fhat_state_t;
endpackage

// ---- core/fhat_sync.sv ----
// Two flip-flop synchroniser, one per bit
`timescale 1ns/100ps
`default_nettype none
module fhat_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					meta_q[i] <= 1'b1;
					sync_out[i] <= 1'b1;
				end else begin
					meta_q[i] <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- core/fhat_fifo.sv ----
// Endpoint data FIFO with registered status flags
`timescale 1ns/100ps
`default_nettype none
module fhat_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic push;
	logic pop;
	logic [AW-1:0] rd_ptr_d;
	logic [WIDTH-1:0] head_q;

	// Handshakes only count when the flags allow them
	assign push = in_valid_in && in_ready_out;
	assign pop = out_ready_in && out_valid_out;
	assign out_data_out = head_q;
	assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;

	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	// Storage has no reset; head word kept in a flop so reads leave a register
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
		if (push && wr_ptr_q == rd_ptr_d) begin
			head_q <= in_data_in; // Word lands straight in the head slot
		end else begin
			head_q <= mem_q[rd_ptr_d];
		end
	end

	// Flags are registered so the outputs come from flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			in_ready_out <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_d;
			in_ready_out <= (count_d != (AW+1)'(DEPTH));
			out_valid_out <= (count_d != '0);
		end
	end
endmodule
`default_nettype wire

// ---- core/fhat_port.sv ----
// Flash-like host port: ready timing, burst pacing and reference strap capture
// Contract
// RQ1: Async 16-bit read: ready 6..8 clocks
// RQ2: Async 32-bit read: 5..7 then 2..4
// RQ3: Async FIFO read: ready 3..4 clocks; without DMA request the code uses the 7-clock 16-bit read timing
// RQ4: Async 16-bit write: ready 3..5 clocks
// RQ5: Async 32-bit write: 2..4 then 3..7
// RQ6: Async FIFO write: ready 3..4 clocks
// RQ7: Ready driven low while async select held
// RQ8: Sync select drives ready; data on interface clock
// RQ9: Burst delay follows wait count, 1..32 clocks
// RQ10: Non-DMA sync reads ignore wait count
// RQ11: DMA burst writes: wait count plus one; code gives one interface clock for a count of 1
// RQ12: Host interface clock period at least 14.8ns
// RQ13: Source strap low selects high reference clock
// RQ14: Both straps high select low reference clock
// RQ15: Straps captured at reset release, then frozen
// RQ16: Ready delays counted in free-running core clocks
// RQ17: Registers only under async select; FIFO either
// RQ18: Address latched on address-valid rising edge
`timescale 1ns/100ps
`default_nettype none
module fhat_port (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic async_cs_n_in,
	input wire logic sync_cs_n_in,
	input wire logic addr_valid_n_in,
	input wire logic output_enable_n_in,
	input wire logic write_enable_n_in,
	input wire logic if_clk_in,
	input wire logic dma_request_in,
	input wire logic [15:0] ad_in,
	output logic [15:0] ad_out,
	output logic [15:0] ad_oe_out,
	output logic access_ready_out,
	output logic access_ready_oe_out,
	input wire logic refclk_source_strap_in,
	input wire logic refclk_freq_strap_in,
	output logic refclk_use_high_out,
	output logic refclk_use_low_out,
	output logic refclk_sel_valid_out,
	input wire logic [15:0] rx_data_in,
	input wire logic rx_valid_in,
	output logic rx_ready_out,
	output logic [15:0] tx_data_out,
	output logic tx_valid_out,
	output logic [4:0] burst_wait_count_out
);
	logic [fhat_pkg::SY_W-1:0] pins_raw;
	logic [fhat_pkg::SY_W-1:0] pins_s;
	logic [15:0] ad_s;
	logic acs_s, scs_s, adv_s, oe_s, we_s, ifclk_s, dma_s;
	logic adv_prev_q, oe_prev_q, we_prev_q, ifclk_prev_q;
	logic adv_rise, oe_fall, we_fall, ifclk_rise;
	logic sel_async, sel_sync, sel_any;
	fhat_pkg::fhat_state_t st_q;
	logic [15:0] addr_q;
	logic half_q;
	logic is_rd_q;
	logic is_fifo_q;
	logic [fhat_pkg::CNT_W-1:0] cnt_q;
	logic [fhat_pkg::CNT_W-1:0] async_ld;
	logic [fhat_pkg::CNT_W-1:0] burst_ld;
	logic addr_fifo, addr_wide, start_rd;
	logic fifo_valid;
	logic [15:0] fifo_data;
	logic pop_q;
	logic [15:0] reg_rdata;
	logic [1:0] strap_cnt_q;
	logic strap_done_q;

	// Every pin passes two flops before any logic reads it
	assign pins_raw = {refclk_freq_strap_in, refclk_source_strap_in, dma_request_in,
		if_clk_in, write_enable_n_in, output_enable_n_in, addr_valid_n_in,
		sync_cs_n_in, async_cs_n_in, ad_in};

	fhat_sync #(
		.WIDTH(fhat_pkg::SY_W)
	) u_sync (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	assign ad_s = pins_s[fhat_pkg::SY_AD_LSB +: 16];
	assign acs_s = pins_s[fhat_pkg::SY_ACS];
	assign scs_s = pins_s[fhat_pkg::SY_SCS];
	assign adv_s = pins_s[fhat_pkg::SY_ADV];
	assign oe_s = pins_s[fhat_pkg::SY_OE];
	assign we_s = pins_s[fhat_pkg::SY_WE];
	assign ifclk_s = pins_s[fhat_pkg::SY_IFCLK];
	assign dma_s = pins_s[fhat_pkg::SY_DMA];

	// Edge history of the synchronised controls
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			adv_prev_q <= 1'b1;
			oe_prev_q <= 1'b1;
			we_prev_q <= 1'b1;
			ifclk_prev_q <= 1'b1; // Synchroniser resets high; avoids a false rise
		end else begin
			adv_prev_q <= adv_s;
			oe_prev_q <= oe_s;
			we_prev_q <= we_s;
			ifclk_prev_q <= ifclk_s;
		end
	end

	// Edge detectors and select decode; async select wins if both are low
	assign adv_rise = adv_s && !adv_prev_q;
	assign oe_fall = !oe_s && oe_prev_q;
	assign we_fall = !we_s && we_prev_q;
	assign ifclk_rise = ifclk_s && !ifclk_prev_q; // RQ12
	assign sel_async = !acs_s;
	assign sel_sync = !scs_s && acs_s;
	assign sel_any = sel_async || sel_sync;

	// Address latch and half-word tracking for 32-bit registers
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_q <= fhat_pkg::DATA_RST;
			half_q <= 1'b0;
		end else if (sel_any && adv_rise) begin
			addr_q <= ad_s; // RQ18
			half_q <= 1'b0;
		end else if (st_q == fhat_pkg::FH_READY && oe_s && we_s && !is_fifo_q) begin
			half_q <= addr_q[fhat_pkg::ADDR_WIDE_BIT] && !half_q;
		end
	end

	assign addr_fifo = addr_q[fhat_pkg::ADDR_FIFO_BIT];
	assign addr_wide = addr_q[fhat_pkg::ADDR_WIDE_BIT];
	assign start_rd = oe_fall;

	// Counter load for one asynchronous half-word access
	always_comb begin
		async_ld = fhat_pkg::RD16_LD; // RQ1
		if (start_rd) begin
			if (addr_fifo && dma_s) begin
				async_ld = fhat_pkg::RDFIFO_LD; // RQ3
			end else if (addr_wide && !addr_fifo) begin
				async_ld = half_q ? fhat_pkg::RD32B_LD : fhat_pkg::RD32A_LD; // RQ2
			end else begin
				async_ld = fhat_pkg::RD16_LD; // RQ1
			end
		end else begin
			if (addr_fifo && dma_s) begin
				async_ld = fhat_pkg::WRFIFO_LD; // RQ6
			end else if (addr_wide && !addr_fifo) begin
				async_ld = half_q ? fhat_pkg::WR32B_LD : fhat_pkg::WR32A_LD; // RQ5
			end else begin
				async_ld = fhat_pkg::WR16_LD; // RQ4
			end
		end
	end

	// Interface clocks before the first burst word
	always_comb begin
		burst_ld = fhat_pkg::BURST_ONE;
		if (dma_s && burst_wait_count_out > fhat_pkg::WAIT_MIN_EFF) begin
			burst_ld = {1'b0, burst_wait_count_out} + 1'b1; // RQ9 RQ11
		end else if (!dma_s) begin
			burst_ld = fhat_pkg::BURST_ONE; // RQ10
		end
	end

	// Register read data: the wait count in the low half only
	assign reg_rdata = (addr_q == fhat_pkg::WAIT_REG_ADDR && !half_q) ?
		{11'h000, burst_wait_count_out} : fhat_pkg::DATA_RST;

	// Access sequencer; async delays count core clocks, which never stop; burst waits count interface clocks
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= fhat_pkg::FH_IDLE;
			cnt_q <= '0;
			is_rd_q <= 1'b0;
			is_fifo_q <= 1'b0;
		end else begin
			case (st_q)
				fhat_pkg::FH_IDLE: begin
					if (sel_async && (oe_fall || we_fall)) begin
						is_rd_q <= oe_fall;
						is_fifo_q <= addr_fifo;
						if (async_ld == '0) begin
							st_q <= fhat_pkg::FH_READY;
						end else begin
							cnt_q <= async_ld - 1'b1; // RQ16
							st_q <= fhat_pkg::FH_WAIT;
						end
					end else if (sel_sync && addr_fifo && (oe_fall || we_fall)) begin
						is_rd_q <= oe_fall; // RQ17
						is_fifo_q <= 1'b1;
						cnt_q <= burst_ld;
						st_q <= fhat_pkg::FH_BWAIT;
					end
				end
				fhat_pkg::FH_WAIT: begin
					if (!sel_async) begin
						st_q <= fhat_pkg::FH_IDLE;
					end else if (cnt_q != '0) begin
						cnt_q <= cnt_q - 1'b1;
					end else if (!(is_rd_q && is_fifo_q) || fifo_valid) begin
						st_q <= fhat_pkg::FH_READY;
					end
				end
				fhat_pkg::FH_READY: begin
					if (!sel_async || (oe_s && we_s)) begin
						st_q <= fhat_pkg::FH_IDLE;
					end
				end
				fhat_pkg::FH_BWAIT: begin
					if (!sel_sync) begin
						st_q <= fhat_pkg::FH_IDLE;
					end else if (ifclk_rise) begin
						cnt_q <= cnt_q - 1'b1;
						if (cnt_q == fhat_pkg::BURST_ONE) begin
							st_q <= fhat_pkg::FH_BURST; // RQ9
						end
					end
				end
				fhat_pkg::FH_BURST: begin
					if (!sel_sync || (oe_s && we_s)) begin
						st_q <= fhat_pkg::FH_IDLE;
					end
				end
				default: begin
					st_q <= fhat_pkg::FH_IDLE;
				end
			endcase
		end
	end

	// Ready pin: driven only while selected, high once data is due
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			access_ready_oe_out <= 1'b0;
			access_ready_out <= 1'b0;
		end else begin
			access_ready_oe_out <= sel_any; // RQ7 RQ8
			if (!sel_any) begin
				access_ready_out <= 1'b0; // RQ7
			end else if (st_q == fhat_pkg::FH_IDLE && sel_async && (oe_fall || we_fall)) begin
				access_ready_out <= (async_ld == '0);
			end else if (st_q == fhat_pkg::FH_WAIT && sel_async && cnt_q == '0) begin
				access_ready_out <= !(is_rd_q && is_fifo_q) || fifo_valid; // RQ1 RQ4
			end else if (st_q == fhat_pkg::FH_BWAIT && ifclk_rise) begin
				access_ready_out <= (cnt_q == fhat_pkg::BURST_ONE); // RQ8
			end else if (st_q == fhat_pkg::FH_BURST && ifclk_rise) begin
				access_ready_out <= !is_rd_q || fifo_valid;
			end else if (st_q == fhat_pkg::FH_IDLE || st_q == fhat_pkg::FH_WAIT) begin
				access_ready_out <= 1'b0;
			end else if (st_q == fhat_pkg::FH_READY && oe_s && we_s) begin
				access_ready_out <= 1'b0;
			end
		end
	end

	// Read data driven while output enable is low during a read
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ad_out <= fhat_pkg::DATA_RST;
			ad_oe_out <= '0;
			pop_q <= 1'b0;
		end else begin
			pop_q <= 1'b0;
			if (oe_s || !sel_any) begin
				ad_oe_out <= '0;
			end else if (st_q == fhat_pkg::FH_WAIT && is_rd_q && cnt_q == '0) begin
				if (!is_fifo_q) begin
					ad_out <= reg_rdata;
					ad_oe_out <= '1;
				end else if (fifo_valid) begin
					ad_out <= fifo_data; // RQ3
					ad_oe_out <= '1;
					pop_q <= 1'b1;
				end
			end else if (st_q == fhat_pkg::FH_IDLE && sel_async && oe_fall && async_ld == '0) begin
				ad_out <= reg_rdata; // RQ2
				ad_oe_out <= '1;
			end else if (is_rd_q && ifclk_rise && fifo_valid && ((st_q == fhat_pkg::FH_BWAIT
				&& cnt_q == fhat_pkg::BURST_ONE) || st_q == fhat_pkg::FH_BURST)) begin
				ad_out <= fifo_data; // RQ8
				ad_oe_out <= '1;
				pop_q <= 1'b1;
			end
		end
	end

	// Write capture: wait count register or FIFO data out
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			burst_wait_count_out <= fhat_pkg::WAIT_RST;
			tx_data_out <= fhat_pkg::DATA_RST;
			tx_valid_out <= 1'b0;
		end else begin
			tx_valid_out <= 1'b0;
			if (st_q == fhat_pkg::FH_WAIT && !is_rd_q && cnt_q == '0 && sel_async) begin
				if (is_fifo_q) begin
					tx_data_out <= ad_s; // RQ6
					tx_valid_out <= 1'b1;
				end else if (addr_q == fhat_pkg::WAIT_REG_ADDR && !half_q) begin
					burst_wait_count_out <= ad_s[fhat_pkg::WAIT_W-1:0]; // RQ17
				end
			end else if (st_q == fhat_pkg::FH_BURST && !is_rd_q && ifclk_rise && sel_sync) begin
				tx_data_out <= ad_s; // RQ11
				tx_valid_out <= 1'b1;
			end
		end
	end

	// Receive stream buffered for host reads; empty FIFO stalls ready, except on the first word of a sync burst
	fhat_fifo #(
		.WIDTH(fhat_pkg::DATA_W),
		.DEPTH(fhat_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.in_data_in(rx_data_in),
		.in_valid_in(rx_valid_in),
		.in_ready_out(rx_ready_out),
		.out_data_out(fifo_data),
		.out_valid_out(fifo_valid),
		.out_ready_in(pop_q)
	);

	// Straps settle through the synchroniser, then are frozen
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
			refclk_use_high_out <= 1'b0;
			refclk_use_low_out <= 1'b0;
			refclk_sel_valid_out <= 1'b0;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == fhat_pkg::STRAP_WAIT) begin
				strap_done_q <= 1'b1; // RQ15
				refclk_use_high_out <= !pins_s[fhat_pkg::SY_SRC]; // RQ13
				refclk_use_low_out <= pins_s[fhat_pkg::SY_SRC] && pins_s[fhat_pkg::SY_FRQ]; // RQ14
				refclk_sel_valid_out <= !pins_s[fhat_pkg::SY_SRC] || pins_s[fhat_pkg::SY_FRQ];
			end else begin
				strap_cnt_q <= strap_cnt_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/fhat_port_checker.sv ----
// Timing assertions on the host port pins and strap outputs
`timescale 1ns/100ps
`default_nettype none
module fhat_port_checker (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic async_cs_n_in,
	input wire logic sync_cs_n_in,
	input wire logic addr_valid_n_in,
	input wire logic output_enable_n_in,
	input wire logic write_enable_n_in,
	input wire logic dma_request_in,
	input wire logic [15:0] ad_in,
	input wire logic access_ready_out,
	input wire logic access_ready_oe_out,
	input wire logic refclk_source_strap_in,
	input wire logic refclk_freq_strap_in,
	input wire logic refclk_use_high_out,
	input wire logic refclk_use_low_out
);
	logic [1:0] kind_q;
	logic [2:0] up_q;
	wire logic oe = !output_enable_n_in;
	wire logic we = !write_enable_n_in;
	wire logic rdy = access_ready_out;
	wire logic sa = !async_cs_n_in;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Access kind taken when address valid ends: bit 15 FIFO, bit 14 wide
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			kind_q <= 2'h0;
		end else if ($rose(addr_valid_n_in)) begin
			kind_q <= ad_in[15:14];
		end
	end
	// Edges since reset release, saturating so straps are judged once
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			up_q <= 3'h0;
		end else if (up_q != 3'h7) begin
			up_q <= up_q + 3'h1;
		end
	end
	AST_RD16: assert property ($rose(oe) && sa && kind_q == 2'h0
		|-> !rdy [*6] ##[1:3] rdy) else $error("register read ready off");
	AST_WR16: assert property ($rose(we) && sa && kind_q == 2'h0
		|-> !rdy [*3] ##[1:3] rdy) else $error("register write ready off");
	AST_FIFO_RD: assert property ($rose(oe) && sa && kind_q[1] && dma_request_in
		|-> !rdy [*3] ##[1:2] rdy) else $error("fifo read ready off");
	AST_FIFO_WR: assert property ($rose(we) && sa && kind_q[1] && dma_request_in
		|-> !rdy [*3] ##[1:2] rdy) else $error("fifo write ready off");
	AST_RDY_DRIVEN: assert property ($fell(async_cs_n_in)
		|-> ##[1:3] access_ready_oe_out && !rdy) else $error("ready not driven");
	AST_RDY_RELEASED: assert property ($rose(async_cs_n_in) && sync_cs_n_in
		|-> ##[1:3] !access_ready_oe_out) else $error("ready not released");
	AST_SYNC_LOW: assert property ($fell(sync_cs_n_in) && async_cs_n_in
		|-> ##[1:3] access_ready_oe_out && !rdy) else $error("sync ready not low");
	AST_SYNC_REG: assert property ($rose(we) && !sync_cs_n_in && !sa && !kind_q[1]
		|-> !rdy [*8]) else $error("register taken under sync select");
	AST_REF_HIGH: assert property (up_q == 3'h5 && !refclk_source_strap_in
		|-> refclk_use_high_out && !refclk_use_low_out) else $error("high ref not chosen");
	AST_REF_LOW: assert property (up_q == 3'h5 && refclk_source_strap_in &&
		refclk_freq_strap_in |-> refclk_use_low_out && !refclk_use_high_out)
		else $error("low ref not chosen");
	AST_REF_FROZEN: assert property (up_q == 3'h7
		|-> $stable(refclk_use_high_out) && $stable(refclk_use_low_out))
		else $error("ref choice moved");
	cover property ($rose(oe) && !sync_cs_n_in && dma_request_in);
	cover property ($rose(we) && sa && kind_q == 2'h1);
	cover property (up_q == 3'h5 && refclk_freq_strap_in && refclk_source_strap_in);
endmodule
bind fhat_port fhat_port_checker u_chk (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_cs_n_in(async_cs_n_in),
	.sync_cs_n_in(sync_cs_n_in), .addr_valid_n_in(addr_valid_n_in),
	.output_enable_n_in(output_enable_n_in), .write_enable_n_in(write_enable_n_in),
	.dma_request_in(dma_request_in), .ad_in(ad_in), .access_ready_out(access_ready_out),
	.access_ready_oe_out(access_ready_oe_out), .refclk_source_strap_in(refclk_source_strap_in),
	.refclk_freq_strap_in(refclk_freq_strap_in), .refclk_use_high_out(refclk_use_high_out),
	.refclk_use_low_out(refclk_use_low_out)
);
`default_nettype wire

// ---- tb/fhat_host_model.sv ----
// Host memory controller model driving the multiplexed port pins
`timescale 1ns/100ps
`default_nettype none
module fhat_host_model (
	input wire logic clk_in,
	input wire logic rdy_in,
	input wire logic [15:0] ad_in,
	output logic acs_n_out,
	output logic scs_n_out,
	output logic adv_n_out,
	output logic oe_n_out,
	output logic we_n_out,
	output logic ifclk_out,
	output logic dma_out,
	output logic ad_oe_out,
	output logic [15:0] ad_out
);
	int dly[2];
	logic [15:0] rd[2];
	// Idle bus: nothing selected, link clock parked low
	initial begin
		{acs_n_out, scs_n_out, adv_n_out, oe_n_out, we_n_out} = 5'h1f;
		{ifclk_out, dma_out, ad_oe_out} = 3'h0;
		ad_out = 16'h0000;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Address phase, then n half-words, each strobe held until ready is seen
	task automatic acc(input logic sy, input logic wr, input logic dm, input logic [15:0] a,
		input logic [15:0] w, input int n);
		scs_n_out = !sy;
		acs_n_out = sy;
		dma_out = dm;
		ad_oe_out = 1'b1;
		ad_out = a;
		adv_n_out = 1'b0;
		tick(2);
		adv_n_out = 1'b1;
		tick(1);
		ad_out = w;
		ad_oe_out = wr;
		for (int h = 0; h < n; h++) begin
			oe_n_out = wr;
			we_n_out = !wr;
			dly[h] = -1;
			// Bounded wait; the link clock only runs while a strobe is out
			for (int k = 1; k <= 40 && dly[h] < 0; k++) begin
				if (sy) begin
					tick(4);
					ifclk_out = 1'b1;
					tick(4);
					ifclk_out = 1'b0;
				end else begin
					tick(1);
				end
				if (rdy_in === 1'b1) begin
					dly[h] = k;
				end
			end
			// A synchronous write word is taken on the link edge after ready
			if (sy && wr && dly[h] >= 0) begin
				tick(4);
				ifclk_out = 1'b1;
				tick(4);
				ifclk_out = 1'b0;
			end
			rd[h] = ad_in;
			oe_n_out = 1'b1;
			we_n_out = 1'b1;
			tick(4);
		end
		{acs_n_out, scs_n_out, dma_out, ad_oe_out} = 4'hc;
		tick(4);
	endtask
endmodule
`default_nettype wire

// ---- tb/flash_like_host_access_timing_tb.sv ----
// Self-checking bench for the host access timing port
`timescale 1ns/100ps
`default_nettype none
module flash_like_host_access_timing_tb;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic src = 1'b0;
	logic frq = 1'b0;
	logic rx_v = 1'b0;
	logic [15:0] rx_d = 16'h0000;
	logic [31:0] seed = 32'h08c0e59e;
	logic [15:0] q[$];
	logic [15:0] txq[$];
	int mismatches = 0;
	int n_tests = 0;
	wire logic acs_n, scs_n, adv_n, oe_n, we_n, ifclk, dma, h_oe, rdy, rdy_oe;
	wire logic rx_rdy, tx_v, u_hi, u_lo, sel_ok;
	wire logic [15:0] h_ad, d_ad, d_oe, tx_d, ad;
	wire logic [4:0] wc_o;
	// Shared data lines: device, else host, else the pull-up
	assign ad = (d_oe & d_ad) | (~d_oe & (h_oe ? h_ad : 16'hffff));
	// Released ready floats; read it high so an undriven pin looks like a false ready
	wire logic rdy_pin = rdy_oe ? rdy : 1'b1;
	always #25 core_clk_in = ~core_clk_in;
	fhat_port DUT (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .async_cs_n_in(acs_n),
		.sync_cs_n_in(scs_n), .addr_valid_n_in(adv_n), .output_enable_n_in(oe_n),
		.write_enable_n_in(we_n), .if_clk_in(ifclk), .dma_request_in(dma), .ad_in(ad),
		.ad_out(d_ad), .ad_oe_out(d_oe), .access_ready_out(rdy), .access_ready_oe_out(rdy_oe),
		.refclk_source_strap_in(src), .refclk_freq_strap_in(frq), .refclk_use_high_out(u_hi),
		.refclk_use_low_out(u_lo), .refclk_sel_valid_out(sel_ok), .rx_data_in(rx_d),
		.rx_valid_in(rx_v), .rx_ready_out(rx_rdy), .tx_data_out(tx_d), .tx_valid_out(tx_v),
		.burst_wait_count_out(wc_o)
	);
	fhat_host_model host (
		.clk_in(core_clk_in), .rdy_in(rdy_pin), .ad_in(ad), .acs_n_out(acs_n),
		.scs_n_out(scs_n), .adv_n_out(adv_n), .oe_n_out(oe_n), .we_n_out(we_n),
		.ifclk_out(ifclk), .dma_out(dma), .ad_oe_out(h_oe), .ad_out(h_ad)
	);
	// Collect every word the port hands out on its write stream
	always @(posedge core_clk_in) begin
		if (tx_v === 1'b1) begin
			txq.push_back(tx_d);
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Burst delay in link clocks; small counts collapse to one
	function automatic int bexp(input logic [4:0] wc, input logic dm);
		return (dm && wc > 5'h01) ? int'(wc) + 1 : 1;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic chkw(input string nm, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			mismatches++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	task automatic do_reset(input logic s, input logic f);
		rst_n_in = 1'b0;
		src = s;
		frq = f;
		repeat (2) @(posedge core_clk_in);
		#1 rst_n_in = 1'b1;
		repeat (6) @(posedge core_clk_in);
		#1;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		logic [4:0] wc;
		logic [15:0] w;
		do_reset(1'b0, 1'b1);
		chk("use_high", 1'b1, u_hi);
		chk("sel_ok", 1'b1, sel_ok);
		src = 1'b1;
		// Fill the receive buffer while the host stalls
		for (int k = 0; k < 40 && rx_rdy === 1'b1; k++) begin
			seed = lfsr(seed);
			rx_d = seed[15:0];
			rx_v = 1'b1;
			q.push_back(rx_d);
			@(posedge core_clk_in);
			#1;
		end
		rx_v = 1'b0;
		chk("fill", fhat_pkg::FIFO_DEPTH, q.size());
		chk("frozen", 1'b1, u_hi);
		// Wait counts: both collapsing values, the largest, one drawn
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wc = (i == 0) ? 5'h00 : (i == 1) ? 5'h01 : (i == 2) ? 5'h1f : seed[4:0];
			w = seed[31:16];
			host.acc(1'b0, 1'b1, 1'b0, fhat_pkg::WAIT_REG_ADDR, {11'h000, wc}, 1);
			chkw("wr16", 3, 5, host.dly[0]);
			chk("wait", wc, wc_o);
			host.acc(1'b0, 1'b0, 1'b0, fhat_pkg::WAIT_REG_ADDR, 16'h0000, 1);
			chkw("rd16", 6, 8, host.dly[0]);
			chk("wait_rd", wc, host.rd[0][4:0]);
			host.acc(1'b1, 1'b1, 1'b1, 16'h8000, w, 1);
			chkw("bwr", bexp(wc, 1'b1), bexp(wc, 1'b1), host.dly[0]);
			chk("btx", w, txq.pop_front());
			host.acc(1'b1, 1'b0, 1'b1, 16'h8000, 16'h0000, 1);
			chkw("brd", bexp(wc, 1'b1), bexp(wc, 1'b1), host.dly[0]);
			chk("brd_d", q.pop_front(), host.rd[0]);
			host.acc(1'b1, 1'b0, 1'b0, 16'h8000, 16'h0000, 1);
			chkw("brd_nd", bexp(wc, 1'b0), bexp(wc, 1'b0), host.dly[0]);
			chk("brd_nd_d", q.pop_front(), host.rd[0]);
		end
		host.acc(1'b0, 1'b1, 1'b0, 16'h4000, w, 2);
		chkw("wr32a", 2, 4, host.dly[0]);
		chkw("wr32b", 3, 7, host.dly[1]);
		host.acc(1'b0, 1'b0, 1'b0, 16'h4000, 16'h0000, 2);
		chkw("rd32a", 5, 7, host.dly[0]);
		chkw("rd32b", 2, 4, host.dly[1]);
		host.acc(1'b0, 1'b1, 1'b1, 16'h8000, w, 2);
		chkw("fwr_a", 3, 4, host.dly[0]);
		chkw("fwr_b", 3, 4, host.dly[1]);
		chk("ftx", {w, w}, {txq.pop_front(), txq.pop_front()});
		// Drain the rest of the buffer in paced pairs
		for (int i = 0; i < 4; i++) begin
			host.acc(1'b0, 1'b0, 1'b1, 16'h8000, 16'h0000, 2);
			chkw("frd_a", 3, 4, host.dly[0]);
			chkw("frd_b", 3, 4, host.dly[1]);
			chk("frd_a_d", q.pop_front(), host.rd[0]);
			chk("frd_b_d", q.pop_front(), host.rd[1]);
		end
		host.acc(1'b1, 1'b1, 1'b0, fhat_pkg::WAIT_REG_ADDR, 16'h0005, 1);
		chkw("refused", -1, -1, host.dly[0]);
		chk("wait_kept", wc, wc_o);
		do_reset(1'b1, 1'b1);
		chk("use_low", 2'h1, {u_hi, u_lo});
		print_verdict();
	end
endmodule
`default_nettype wire
